// ---- src/vpm_datapath.sv ----
// Vector predicate masking datapath: registers, writeback masking, fault-suppressing loads
// Summary of operation
// - element i spans bits i*N up to (i+1)*N-1, element zero lowest.
// - element is active when its governing predicate element is true.
// - unpredicated instructions treat every vector and predicate element as active.
// - first active element is the lowest numbered active element.
// - last active element is the highest numbered active element.
// - merging writeback keeps inactive destination elements unchanged.
// - zeroing writeback clears inactive destination elements to zero.
// - predicate element is 1, 2, 4, 8 or 16 bits, one eighth of vector element.
// - predicate element truth is its lowest bit, one true, zero false.
// - sixteen predicate registers, 16 to 256 bits, multiple of 16.
// - thirty-two vector registers, 128 to 2048 bits, multiple of 128.
// - vector element width 8, 16, 32, 64 or 128 bits per instruction.
// - one common vector length per level, limited by the length controls.
// - predicate and fault status mask width is one eighth of vector length.
// - first-fault load faults only on first active element, marks other failures.
// - non-fault load suppresses all faults, marks failed active elements.
// - memory element size is given per access, apart from vector element size.
// - packed when sizes match, unpacked when vector element is larger.
// - gather and scatter take per-element addresses from a vector register; only the gather address path is handled here.
// - destructive encoding writes the result into its first source register.
// - constructive encoding takes the destination from its own field.
// - the instruction after a move prefix is marked as its prefixed instruction.
`include "vpm_defs.svh"
`default_nettype none
module vpm_datapath
  import vpm_pkg::*;
#(
  parameter int MAX_VL = `VPM_VL_MAX_BITS,
  parameter int NB     = MAX_VL / 8,
  parameter int IW     = $clog2(NB)
)
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  // Register port
  input  wire vpm_bus_t       bus,
  output logic     [31:0]     busRdata,
  // Privilege level in force
  input  wire logic [1:0]     curLevel,
  // Writeback request
  input  wire vpm_wb_t        wb,
  input  wire logic [MAX_VL-1:0] wbData,
  input  wire logic [NB-1:0]  wbPred,
  output logic                prefixedOp,
  output logic     [IW-1:0]   firstActIdx,
  output logic     [IW-1:0]   lastActIdx,
  output logic                anyActive,
  // Load from the memory pipeline
  input  wire vpm_ld_t        ld,
  input  wire logic [NB-1:0]  ldFail,
  input  wire logic           faultMaskSetAll,
  output logic                takeFault,
  output logic                ldPacked,
  output logic                ldUnpacked,
  output logic                ldBadSize,
  output logic [MAX_VL-1:0]   gatherAddr,
  output logic     [NB-1:0]   gatherAct,
  // Register read ports
  input  wire logic [4:0]     rdVecIdx,
  input  wire logic [3:0]     rdPredIdx,
  output logic [MAX_VL-1:0]   rdVec,
  output logic     [NB-1:0]   rdPred
);

  localparam int NW = (NB + 31) / 32;

  logic [3:0]        vlc_q [1:3];
  logic [MAX_VL-1:0] vreg_q [`VPM_VREG_NUM];
  logic [NB-1:0]     preg_q [`VPM_PREG_NUM];
  logic [NB-1:0]     faultMask_q;
  logic              prefixPend_q;
  logic [8:0]        vlBytes;
  logic [NB-1:0]     acc;
  logic [4:0]        dstIdx;
  logic [NB-1:0]     wbAct;
  logic [IW-1:0]     wbFirst;
  logic [IW-1:0]     wbLast;
  logic              wbAny;
  logic [MAX_VL-1:0] wbNew;
  logic [NB-1:0]     wbPredNew;
  logic              wbFire;
  logic [NB-1:0]     ldAct;
  logic              ldFire;
  logic [NB-1:0]     failAct;
  logic              firstFault;
  logic [NB-1:0]     faultMaskSet;
  logic              takeFault_d;

  // Shortest length over the levels that bound the current one
  function automatic logic [8:0] vlBytesOf(input logic [1:0] lvl, input logic [3:0] l1,
                                           input logic [3:0] l2, input logic [3:0] l3);
    logic [3:0] m;
    m = l3;
    if (lvl <= 2'h2 && l2 < m)
    begin
      m = l2;
    end
    if (lvl <= 2'h1 && l1 < m)
    begin
      m = l1;
    end
    vlBytesOf = {1'b0, m, 4'h0} + 9'h010;
  endfunction

  // An inactive lane keeps its old content only under merging and within the length
  function automatic logic keepOld(input logic a, input logic z, input logic inLen);
    keepOld = !a && !z && inLen;
  endfunction

  always_comb
  begin
    vlBytes = vlBytesOf(curLevel, vlc_q[1], vlc_q[2], vlc_q[3]);
    if (vlBytes > 9'(NB))
    begin
      vlBytes = 9'(NB);
    end
    for (int b = 0; b < NB; b++)
    begin
      acc[b] = (9'(b) < vlBytes);
    end
  end

  // Destination selection by encoding form
  always_comb
  begin
    dstIdx = wb.destructive ? wb.src1 : wb.dstFld;
  end

  assign wbFire = wb.valid;
  assign ldFire = ld.valid;

  vpm_elem_mask #(.NB(NB), .IW(IW)) u_wbMask (
    .govPred  (preg_q[wb.govIdx]),
    .esz      (wb.esz),
    .unpred   (!wb.predicated),
    .accMask  (acc),
    .act      (wbAct),
    .firstIdx (wbFirst),
    .lastIdx  (wbLast),
    .anyAct   (wbAny)
  );

  vpm_elem_mask #(.NB(NB), .IW(IW)) u_ldMask (
    .govPred  (preg_q[ld.govIdx]),
    .esz      (ld.esz),
    .unpred   (!ld.predicated),
    .accMask  (acc),
    .act      (ldAct),
    .firstIdx (),
    .lastIdx  (),
    .anyAct   ()
  );

  // Byte lanes follow element layout, so one mask serves every element width
  always_comb
  begin
    wbNew = '0;
    wbPredNew = '0;
    for (int b = 0; b < NB; b++)
    begin
      if (wbAct[b])
      begin
        wbNew[b*8 +: 8] = wbData[b*8 +: 8];
        wbPredNew[b] = wbPred[b];
      end
      else if (keepOld(wbAct[b], wb.zeroing, acc[b]))
      begin
        wbNew[b*8 +: 8] = vreg_q[dstIdx][b*8 +: 8];
        wbPredNew[b] = preg_q[dstIdx[3:0]][b];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int r = 0; r < `VPM_VREG_NUM; r++)
      begin
        vreg_q[r] <= '0;
      end
    end
    else if (wbFire && !wb.predDest)
    begin
      vreg_q[dstIdx] <= wbNew;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int r = 0; r < `VPM_PREG_NUM; r++)
      begin
        preg_q[r] <= '0;
      end
    end
    else if (wbFire && wb.predDest)
    begin
      preg_q[dstIdx[3:0]] <= wbPredNew;
    end
  end

  // Pending flag survives idle cycles until the next issued instruction
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prefixPend_q <= 1'b0;
    end
    else if (wbFire)
    begin
      prefixPend_q <= wb.movePrefix;
    end
  end

  assign prefixedOp = wbFire && prefixPend_q;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      firstActIdx <= '0;
      lastActIdx <= '0;
      anyActive <= 1'b0;
    end
    else if (wbFire)
    begin
      firstActIdx <= wbFirst;
      lastActIdx <= wbLast;
      anyActive <= wbAny;
    end
  end

  // Load fault handling
  always_comb
  begin
    failAct = ldAct & ldFail;
    firstFault = |(ldAct & (~ldAct + NB'(1)) & ldFail);
    unique case (ld.mode)
      VPM_LD_FF: takeFault_d = firstFault;
      VPM_LD_NF: takeFault_d = 1'b0;
      default:   takeFault_d = |failAct;
    endcase
  end

  always_comb
  begin
    faultMaskSet = faultMaskSetAll ? acc : '0;
  end

  // A fault mark in the same cycle as a set-all wins over the set
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      faultMask_q <= '0;
    end
    else if (ldFire && ld.mode != VPM_LD_NORM && !takeFault_d)
    begin
      faultMask_q <= ((faultMask_q | faultMaskSet) & ~failAct) & acc;
    end
    else
    begin
      faultMask_q <= (faultMask_q | faultMaskSet) & acc;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      takeFault <= 1'b0;
      ldPacked <= 1'b0;
      ldUnpacked <= 1'b0;
      ldBadSize <= 1'b0;
    end
    else
    begin
      takeFault <= ldFire && takeFault_d;
      ldPacked <= ldFire && (ld.esz == ld.msz);
      ldUnpacked <= ldFire && (ld.esz > ld.msz);
      ldBadSize <= ldFire && (ld.esz < ld.msz);
    end
  end

  // Address vector and lane mask for gather loads
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gatherAddr <= '0;
      gatherAct <= '0;
    end
    else if (ldFire && ld.gather)
    begin
      gatherAddr <= vreg_q[ld.addrIdx];
      gatherAct <= ldAct;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdVec <= '0;
      rdPred <= '0;
    end
    else
    begin
      rdVec <= vreg_q[rdVecIdx];
      rdPred <= preg_q[rdPredIdx];
    end
  end

  // Register port
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int l = 1; l <= 3; l++)
      begin
        vlc_q[l] <= `VPM_VLC_RST;
      end
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        `VPM_OFF_VLC1: vlc_q[1] <= bus.wdata[`VPM_LEN_LSB +: `VPM_LEN_W];
        `VPM_OFF_VLC2: vlc_q[2] <= bus.wdata[`VPM_LEN_LSB +: `VPM_LEN_W];
        `VPM_OFF_VLC3: vlc_q[3] <= bus.wdata[`VPM_LEN_LSB +: `VPM_LEN_W];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busRdata <= '0;
    end
    else
    begin
      busRdata <= '0;
      if (bus.rd)
      begin
        unique case (bus.addr)
          `VPM_OFF_VLC1: busRdata <= {28'h0000000, vlc_q[1]};
          `VPM_OFF_VLC2: busRdata <= {28'h0000000, vlc_q[2]};
          `VPM_OFF_VLC3: busRdata <= {28'h0000000, vlc_q[3]};
          `VPM_OFF_VLEN: busRdata <= {23'h000000, vlBytes};
          default:
          begin
            for (int w = 0; w < NW; w++)
            begin
              if (bus.addr == `VPM_OFF_FMASK + 8'(w * 4))
              begin
                busRdata <= 32'(faultMask_q >> (w * 32));
              end
            end
          end
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_zeroIn;
    wbFire && !wb.predDest && wb.zeroing && !wbAct[0];
  endsequence

  sequence s_mergeIn;
    wbFire && !wb.predDest && !wb.zeroing && !wbAct[0];
  endsequence

  sequence s_pfx;
    wbFire && wb.movePrefix;
  endsequence

  AST_ZERO_INACTIVE: assert property (s_zeroIn |=> vreg_q[$past(dstIdx)][7:0] == 8'h00)
    else $error("inactive lane not zeroed");
  AST_MERGE_KEEP: assert property (s_mergeIn |-> wbNew[7:0] == vreg_q[dstIdx][7:0])
    else $error("inactive lane not kept");
  AST_DESTRUCT: assert property (wbFire && wb.destructive |-> dstIdx == wb.src1)
    else $error("destructive destination wrong");
  AST_CONSTRUCT: assert property (wbFire && !wb.destructive |-> dstIdx == wb.dstFld)
    else $error("constructive destination wrong");
  AST_PREFIXED: assert property (s_pfx ##1 wbFire [*1] |-> prefixedOp)
    else $error("prefixed instruction not marked");
  AST_PREFIX_HELD: assert property (s_pfx ##1 (!wbFire) [*3] ##1 wbFire |-> prefixedOp)
    else $error("prefix lost across idle cycles");
  AST_NF_NOFAULT: assert property (ldFire && ld.mode == VPM_LD_NF |=> !takeFault)
    else $error("non-fault load raised a fault");
  AST_FF_FIRST: assert property (ldFire && ld.mode == VPM_LD_FF && firstFault |=> takeFault)
    else $error("first element fault missed");
  AST_FMASK_MARK: assert property (ldFire && ld.mode == VPM_LD_NF && failAct[0] |=> !faultMask_q[0])
    else $error("failed element not marked");
  AST_UNPRED_ALL: assert property (wbFire && !wb.predicated |-> wbAct == acc)
    else $error("unpredicated lane inactive");
  AST_PACKED: assert property (ldFire && ld.esz == ld.msz |=> ldPacked && !ldUnpacked)
    else $error("packed access misclassed");

endmodule
`default_nettype wire

// ---- common/vpm_defs.svh ----
// Register offsets, reset values and field positions of the predicate masking block
`ifndef VPM_DEFS_SVH
`define VPM_DEFS_SVH

`define VPM_OFF_VLC1      8'h00
`define VPM_OFF_VLC2      8'h04
`define VPM_OFF_VLC3      8'h08
`define VPM_OFF_VLEN      8'h0C
`define VPM_OFF_FMASK     8'h40
`define VPM_LEN_LSB       0
`define VPM_LEN_W         4
`define VPM_VLC_RST       4'hF
`define VPM_VREG_NUM      32
`define VPM_PREG_NUM      16
`define VPM_VL_GRAN_BITS  128
`define VPM_VL_MAX_BITS   2048

`endif

// ---- common/vpm_pkg.sv ----
// Types shared by the predicate masking datapath
`default_nettype none
package vpm_pkg;

  typedef enum logic [2:0] {
    VPM_E8   = 3'h0,
    VPM_E16  = 3'h1,
    VPM_E32  = 3'h2,
    VPM_E64  = 3'h3,
    VPM_E128 = 3'h4
  } vpm_esz_t;

  typedef enum logic [1:0] {
    VPM_LD_NORM = 2'h0,
    VPM_LD_FF   = 2'h1,
    VPM_LD_NF   = 2'h2
  } vpm_ldmode_t;

  typedef struct packed {
    logic       valid;
    logic       destructive;
    logic [4:0] dstFld;
    logic [4:0] src1;
    logic [3:0] govIdx;
    logic       predicated;
    logic       zeroing;
    logic       predDest;
    logic       movePrefix;
    vpm_esz_t   esz;
  } vpm_wb_t;

  typedef struct packed {
    logic        valid;
    vpm_ldmode_t mode;
    vpm_esz_t    esz;
    vpm_esz_t    msz;
    logic [3:0]  govIdx;
    logic        predicated;
    logic        gather;
    logic [4:0]  addrIdx;
  } vpm_ld_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } vpm_bus_t;

endpackage
`default_nettype wire

// ---- src/vpm_elem_mask.sv ----
// Active byte mask and first/last active element from a governing predicate
`default_nettype none
module vpm_elem_mask
  import vpm_pkg::*;
#(
  parameter int NB = 256,
  parameter int IW = $clog2(NB)
)
(
  // Predicate and element shape
  input  wire logic [NB-1:0] govPred,
  input  wire vpm_esz_t      esz,
  input  wire logic          unpred,
  input  wire logic [NB-1:0] accMask,
  // Results
  output logic      [NB-1:0] act,
  output logic      [IW-1:0] firstIdx,
  output logic      [IW-1:0] lastIdx,
  output logic               anyAct
);

  logic [IW-1:0] grp;
  logic [IW-1:0] fb;
  logic [IW-1:0] lb;

  // One predicate bit per vector byte; the element's truth sits in its lowest bit
  always_comb
  begin
    grp = IW'((1 << esz) - 1);
    fb = '0;
    lb = '0;
    anyAct = 1'b0;
    act = '0;
    for (int b = 0; b < NB; b++)
    begin
      act[b] = accMask[b] & (unpred | govPred[IW'(b) & ~grp]);
      if (act[b] && !anyAct)
      begin
        fb = IW'(b);
      end
      if (act[b])
      begin
        lb = IW'(b);
        anyAct = 1'b1;
      end
    end
    firstIdx = fb >> esz;
    lastIdx = lb >> esz;
  end

endmodule
`default_nettype wire

// ---- verification/vpm_mem_model.sv ----
// Load pipeline model: lanes at or above a fault boundary fail to load
`default_nettype none
module vpm_mem_model
#(
  parameter int NB = 32
)
(
  // Clock and load request
  input  wire logic          ref_clk,
  input  wire logic          req,
  input  wire logic [7:0]    faultLane,
  // Per-lane failure flags
  output logic      [NB-1:0] ldFail
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NB-1:0] junk = NB'(32'h5A5A5A5A);

  // Outside a request the flags are meaningless, so they toggle every cycle
  always @(posedge ref_clk)
    junk <= ~junk;

  // A page boundary: the first failing lane and every lane above it fail
  assign ldFail = req ? ({NB{1'b1}} << faultLane) : junk;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the predicate masking datapath
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
module testbench
  import vpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MV = 256;
  localparam int NB = 32;
  localparam int IW = 5;

  logic          ref_clk = 1'b0;
  logic          resetn = 1'b0;
  vpm_bus_t      bus = '0;
  logic [31:0]   busRdata;
  logic [1:0]    curLevel = 2'h1;
  vpm_wb_t       wb = '0;
  vpm_wb_t       rw;
  vpm_ld_t       ld = '0;
  logic [MV-1:0] wbData = '0;
  logic [MV-1:0] rdVec;
  logic [MV-1:0] gatherAddr;
  logic [NB-1:0] wbPred = '0;
  logic [NB-1:0] ldFail;
  logic [NB-1:0] rdPred;
  logic [NB-1:0] gatherAct;
  logic [NB-1:0] faultMask = '0;
  logic [IW-1:0] firstActIdx;
  logic [IW-1:0] lastActIdx;
  logic          prefixedOp;
  logic          anyActive;
  logic          takeFault;
  logic          ldPacked;
  logic          ldUnpacked;
  logic          ldBadSize;
  logic          faultMaskSetAll = 1'b0;
  logic          lastPfx = 1'b0;
  logic [7:0]    faultLane = '0;
  logic [4:0]    rdVecIdx = '0;
  logic [3:0]    rdPredIdx = '0;
  logic [31:0]   rng = 32'hB352;
  logic [MV-1:0] vm [32] = '{default: '0};
  logic [NB-1:0] pm [16] = '{default: '0};
  int            n_errors = 0;
  int            tests_run = 0;

  vpm_datapath #(.MAX_VL(MV)) vpm_datapath_inst (
    .ref_clk(ref_clk), .resetn(resetn), .bus(bus), .busRdata(busRdata),
    .curLevel(curLevel), .wb(wb), .wbData(wbData), .wbPred(wbPred),
    .prefixedOp(prefixedOp), .firstActIdx(firstActIdx), .lastActIdx(lastActIdx),
    .anyActive(anyActive), .ld(ld), .ldFail(ldFail), .faultMaskSetAll(faultMaskSetAll),
    .takeFault(takeFault), .ldPacked(ldPacked), .ldUnpacked(ldUnpacked),
    .ldBadSize(ldBadSize), .gatherAddr(gatherAddr), .gatherAct(gatherAct),
    .rdVecIdx(rdVecIdx), .rdPredIdx(rdPredIdx), .rdVec(rdVec), .rdPred(rdPred));

  vpm_mem_model #(.NB(NB)) vpm_mem_model_inst (
    .ref_clk(ref_clk), .req(ld.valid), .faultLane(faultLane), .ldFail(ldFail));

  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    `CHK(busRdata, e)
  endtask

  task automatic set_all();
    @(posedge ref_clk);
    faultMaskSetAll <= 1'b1;
    @(posedge ref_clk);
    faultMaskSetAll <= 1'b0;
  endtask

  // Model writes the destination first, then drives the same request to the design
  task automatic issue(input vpm_wb_t w, input logic [MV-1:0] d, input logic [NB-1:0] p);
    int nb;
    int fi;
    int la;
    logic act;
    logic [4:0] dst;
    logic [NB-1:0] g;
    w.valid = 1'b1;
    nb = 1 << w.esz;
    dst = w.destructive ? w.src1 : w.dstFld;
    g = w.predicated ? pm[w.govIdx] : '1;
    fi = -1;
    la = 0;
    for (int i = 0; i < NB / nb; i++)
    begin
      act = g[i * nb];
      if (act && fi < 0)
        fi = i;
      if (act)
        la = i;
      for (int b = i * nb; b < (i + 1) * nb; b++)
        if (w.predDest && (act || w.zeroing))
          pm[dst[3:0]][b] = act & p[b];
        else if (!w.predDest && (act || w.zeroing))
          vm[dst][b * 8 +: 8] = act ? d[b * 8 +: 8] : 8'h0;
    end
    @(posedge ref_clk);
    wb <= w;
    wbData <= d;
    wbPred <= p;
    #1;
    `CHK(prefixedOp, lastPfx)
    lastPfx = w.movePrefix;
    @(posedge ref_clk);
    wb.valid <= 1'b0;
    #1;
    `CHK(anyActive, fi >= 0)
    if (fi >= 0)
    begin
      `CHK(firstActIdx, IW'(fi))
      `CHK(lastActIdx, IW'(la))
    end
    @(posedge ref_clk);
    rdVecIdx <= dst;
    rdPredIdx <= dst[3:0];
    @(posedge ref_clk);
    #1;
    `CHK(rdVec, vm[dst])
    `CHK(rdPred, pm[dst[3:0]])
  endtask

  task automatic load(input vpm_ld_t l, input logic [7:0] fl);
    int fi;
    logic ef;
    logic [NB-1:0] g;
    logic [NB-1:0] a;
    logic [NB-1:0] f;
    l.valid = 1'b1;
    g = l.predicated ? pm[l.govIdx] : '1;
    for (int b = 0; b < NB; b++)
      a[b] = g[(b >> l.esz) << l.esz];
    f = {NB{1'b1}} << fl;
    fi = NB;
    for (int b = NB - 1; b >= 0; b--)
      if (a[b])
        fi = b;
    ef = (l.mode == VPM_LD_NF) ? 1'b0 : (l.mode == VPM_LD_FF) ? (fi < NB && f[fi]) : |(a & f);
    if (l.mode != VPM_LD_NORM && !ef)
      faultMask &= ~(a & f);
    @(posedge ref_clk);
    ld <= l;
    faultLane <= fl;
    @(posedge ref_clk);
    ld.valid <= 1'b0;
    #1;
    `CHK(takeFault, ef)
    `CHK(ldPacked, l.esz == l.msz)
    `CHK(ldUnpacked, l.esz > l.msz)
    `CHK(ldBadSize, l.esz < l.msz)
    if (l.gather)
    begin
      `CHK(gatherAddr, vm[l.addrIdx])
      `CHK(gatherAct, a)
    end
    rd(8'h40, faultMask);
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(8'h00, 32'hF);
    rd(8'h0C, 32'd32);
    rd(8'h40, 32'h0);
    rd(8'h80, 32'h0);
    wr(8'h00, 32'hFFFF_FFF0);
    wr(8'h0C, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'd16);
    set_all();
    rd(8'h40, 32'h0000_FFFF);
    @(posedge ref_clk);
    curLevel <= 2'h2;
    rd(8'h0C, 32'd32);
    wr(8'h08, 32'h0);
    rd(8'h0C, 32'd16);
    wr(8'h08, 32'hF);
    wr(8'h00, 32'hF);
    @(posedge ref_clk);
    curLevel <= 2'h1;
    rd(8'h0C, 32'd32);
    $display("test length done");
    for (int k = 0; k < 60; k++)
    begin
      rw = vpm_wb_t'(23'(rnd()));
      // Element size codes above 128 bits are refused, so keep to the five legal ones
      rw.esz = vpm_esz_t'(3'(rnd() % 5));
      issue(rw, {8{rnd()}}, rnd());
    end
    $display("test writeback done");
    set_all();
    faultMask = '1;
    // First pass of each mode is unpredicated with every lane failing, so lane 0 fails
    for (int k = 0; k < 9; k++)
      load('{1'b1, vpm_ldmode_t'(k % 3), VPM_E8, VPM_E8, 4'(rnd()), (k >= 3) & 1'(rnd()),
             1'(rnd()), 5'(rnd())}, (k < 3) ? 8'h00 : 8'(rnd() % 34));
    for (int e = 0; e < 25; e++)
      load('{1'b1, VPM_LD_NORM, vpm_esz_t'(e / 5), vpm_esz_t'(e % 5), 4'h0, 1'b0,
             1'b1, 5'(e)}, 8'(NB));
    $display("test load done");
    complete_run();
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
